// [core/charge_box_power_supervisor.sv]
// Charge box supervisor: charger sequencing, input priority, NTC and protection
//
// Behaviour
// [R01] Below precharge threshold charge at one tenth of constant current.
// [R02] Above precharge threshold switch to constant-current charging.
// [R03] Near selected target voltage enter constant-voltage; four target options.
// [R04] After completion restart charging when battery drops below recharge threshold.
// [R05] Cap current at maximum; derate on die heat or input sag.
// [R06] Constant current chosen from strap resistor code.
// [R07] Wired input wins over wireless; wireless receiver is disabled.
// [R08] Detect fitted LED count and select display mode.
// [R09] Four-LED discharge bars at 75, 50, 25 percent.
// [R10] Discharge below low threshold blinks first LED at 1 Hz; two-LED mode blinks the second LED instead.
// [R11] Source thermistor bias and judge temperature by comparators.
// [R12] Charging stops when thermistor voltage above cold limit.
// [R13] Charging stops when thermistor voltage below hot limit.
// [R14] Discharging stops when thermistor voltage above discharge cold limit.
// [R15] Discharging stops when thermistor voltage below discharge hot limit.
// [R16] Boost shuts down on overcurrent, short, overvoltage, over-temperature.
// [R17] Charging three/four LED: lower steady, band blinks 0.5 Hz, full steady.
// [R18] Three-LED discharge bars at two thirds and one third.
// [R19] One/two LED: charge blink or steady full, discharge steady or blink.
`timescale 1ns/1ns
module charge_box_power_supervisor
	import supervisor_pkg::*;
#(
	parameter int HALF_FAST_CYC = HALF_FAST,
	parameter int HALF_SLOW_CYC = HALF_SLOW,
	parameter int SETTLE_CYC = STRAP_SETTLE
)(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire sense_t sense_in,
	input wire logic wired_present_in,
	input wire logic wireless_present_in,
	input wire logic battery_present_in,
	input wire logic discharge_request_in,
	input wire logic [1:0] target_select_in,
	input wire logic [1:0] charge_current_select_pin_in,
	input wire logic [3:0] led_fitted_in,
	input wire logic [6:0] capacity_in,
	output power_cmd_t power_cmd_out,
	output logic thermistor_sense_pin_bias_out,
	output logic charging_out,
	output logic charge_full_out,
	output logic boost_fault_out,
	output logic [2:0] led_mode_out,
	output logic [3:0] level_indicator_out
);
	typedef struct packed {
		charge_state_t st;
		logic [10:0] settle_cnt;
		logic straps_valid;
		logic [9:0] cc_ma;
		logic [2:0] led_count;
		logic boost_latch;
		power_cmd_t cmd;
	} sup_state_t;

	sup_state_t s_r;
	sup_state_t s_nxt;
	logic source_ok;
	logic charge_temp_ok;
	logic discharge_temp_ok;
	logic fault_now;
	logic [9:0] derated_ma;
	logic [9:0] pre_ma;

	////////////////////////////////////////////////////////////////
	// Strap decoding
	function automatic logic [9:0] strap_to_ma(input logic [1:0] code);
		logic [9:0] ma;
		ma = CUR_MAX_MA;
		case (code)
			2'h0: ma = 10'h064;
			2'h1: ma = 10'h0c8;
			2'h2: ma = 10'h12c;
			default: ma = CUR_MAX_MA;
		endcase
		return ma;
	endfunction

	function automatic logic [2:0] count_leds(input logic [3:0] fitted);
		logic [2:0] n;
		n = 3'h1;
		if (fitted[3])
			n = 3'h4;
		else if (fitted[2])
			n = 3'h3;
		else if (fitted[1])
			n = 3'h2;
		return n;
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_nxt = s_r;
		// [R07] Either wired or wireless input is a charge source
		source_ok = wired_present_in | wireless_present_in;
		// [R12] [R13] Charge temperature window
		charge_temp_ok = ~sense_in.ntc_above_1v30 & ~sense_in.ntc_below_0v50;
		// [R14] [R15] Discharge temperature window
		discharge_temp_ok = ~sense_in.ntc_above_1v47 & ~sense_in.ntc_below_0v44;
		// [R16] Boost protection sources
		fault_now = sense_in.out_overcurrent | sense_in.out_short
			| sense_in.out_overvoltage | sense_in.die_overtemp;
		// [R05] Thermal and sag derating
		derated_ma = (s_r.cc_ma > CUR_MAX_MA) ? CUR_MAX_MA : s_r.cc_ma;
		if (sense_in.die_hot || sense_in.vin_sag)
			derated_ma = (derated_ma > DERATE_STEP_MA) ? derated_ma - DERATE_STEP_MA
				: derated_ma >> 1;
		// [R01] One tenth precharge
		pre_ma = 10'(derated_ma / 10'(PRE_DIVISOR));

		// Straps sampled after reset settle, then frozen
		if (!s_r.straps_valid)
		begin
			if (s_r.settle_cnt >= 11'(SETTLE_CYC - 1))
			begin
				s_nxt.straps_valid = 1'b1;
				// [R06] Strap current select
				s_nxt.cc_ma = strap_to_ma(charge_current_select_pin_in);
				// [R08] LED count detect
				s_nxt.led_count = count_leds(led_fitted_in);
			end
			else
				s_nxt.settle_cnt = s_r.settle_cnt + 11'h1;
		end

		case (s_r.st)
			CH_IDLE:
			begin
				if (s_r.straps_valid && source_ok && battery_present_in && charge_temp_ok)
					s_nxt.st = sense_in.bat_above_pre ? CH_CC : CH_PRE;
			end
			CH_PRE:
			begin
				// [R02] Precharge to CC
				if (sense_in.bat_above_pre)
					s_nxt.st = CH_CC;
			end
			CH_CC:
			begin
				// [R03] CC to CV
				if (sense_in.bat_near_target)
					s_nxt.st = CH_CV;
				else if (!sense_in.bat_above_pre)
					s_nxt.st = CH_PRE;
			end
			CH_CV:
			begin
				if (sense_in.charge_end_current)
					s_nxt.st = CH_DONE;
			end
			CH_DONE:
			begin
				// [R04] Recharge restart
				// A deeply drained cell restarts in precharge
				if (sense_in.bat_below_rech)
					s_nxt.st = sense_in.bat_above_pre ? CH_CC : CH_PRE;
			end
			default:
				s_nxt.st = CH_IDLE;
		endcase
		// Source or temperature loss aborts charging
		if (!source_ok || !battery_present_in || !charge_temp_ok)
			s_nxt.st = CH_IDLE;

		// Fault latch clears only with no fault and no output request
		if (fault_now)
			s_nxt.boost_latch = 1'b1;
		else if (!discharge_request_in)
			s_nxt.boost_latch = 1'b0;

		s_nxt.cmd.charge_en = (s_nxt.st == CH_PRE) || (s_nxt.st == CH_CC)
			|| (s_nxt.st == CH_CV);
		s_nxt.cmd.cv_mode = (s_nxt.st == CH_CV);
		s_nxt.cmd.current_ma = (s_nxt.st == CH_PRE) ? pre_ma
			: (s_nxt.cmd.charge_en ? derated_ma : 10'h000);
		s_nxt.cmd.target_sel = target_select_in;
		// [R07] Wireless receiver off
		s_nxt.cmd.wireless_rx_disable = wired_present_in;
		// [R16] Boost gating
		s_nxt.cmd.boost_en = discharge_request_in && discharge_temp_ok
			&& !fault_now && !s_r.boost_latch && !source_ok;
		// [R11] Thermistor bias
		s_nxt.cmd.ntc_bias_en = 1'b1;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			s_r <= '0;
			s_r.st <= CH_IDLE;
			s_r.led_count <= 3'h1;
		end
		else
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////
	assign power_cmd_out = s_r.cmd;
	assign thermistor_sense_pin_bias_out = s_r.cmd.ntc_bias_en;
	assign charging_out = (s_r.st != CH_IDLE);
	assign charge_full_out = (s_r.st == CH_DONE);
	assign boost_fault_out = s_r.boost_latch;
	assign led_mode_out = s_r.led_count;

	led_indicator #(
		.HALF_FAST_CYC(HALF_FAST_CYC),
		.HALF_SLOW_CYC(HALF_SLOW_CYC)
	) u_led (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.led_count_in(s_r.led_count),
		.charging_in(charging_out),
		.full_in(charge_full_out),
		.capacity_in(capacity_in),
		.level_indicator_out(level_indicator_out)
	);
endmodule

// [core/led_indicator.sv]
// Battery level indicator pattern generator for one to four LEDs
`timescale 1ns/1ns
module led_indicator
	import supervisor_pkg::*;
#(
	parameter int HALF_FAST_CYC = HALF_FAST,
	parameter int HALF_SLOW_CYC = HALF_SLOW
)(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [2:0] led_count_in,
	input wire logic charging_in,
	input wire logic full_in,
	input wire logic [6:0] capacity_in,
	output logic [3:0] level_indicator_out
);
	typedef struct packed {
		logic [25:0] fast_cnt;
		logic [25:0] slow_cnt;
		logic fast_ph;
		logic slow_ph;
		logic [3:0] leds;
	} led_state_t;

	led_state_t s_r;
	led_state_t s_nxt;
	logic [2:0] band;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_nxt = s_r;
		band = 3'h0;
		if (s_r.fast_cnt >= 26'(HALF_FAST_CYC - 1))
		begin
			s_nxt.fast_cnt = 26'h0;
			s_nxt.fast_ph = ~s_r.fast_ph;
		end
		else
			s_nxt.fast_cnt = s_r.fast_cnt + 26'h1;
		if (s_r.slow_cnt >= 26'(HALF_SLOW_CYC - 1))
		begin
			s_nxt.slow_cnt = 26'h0;
			s_nxt.slow_ph = ~s_r.slow_ph;
		end
		else
			s_nxt.slow_cnt = s_r.slow_cnt + 26'h1;
		// Band index: number of fully lit LEDs below the active one
		if (led_count_in == 3'h4)
		begin
			if (capacity_in >= PCT_75)
				band = 3'h3;
			else if (capacity_in >= PCT_50)
				band = 3'h2;
			else if (capacity_in >= PCT_25)
				band = 3'h1;
		end
		else
		begin
			if (capacity_in >= PCT_66)
				band = 3'h2;
			else if (capacity_in >= PCT_33)
				band = 3'h1;
		end
		s_nxt.leds = 4'h0;
		if (led_count_in >= 3'h3)
		begin
			if (charging_in && full_in)
				s_nxt.leds = (led_count_in == 3'h4) ? 4'hf : 4'h7;
			// [R17] Charge band blink
			else if (charging_in)
				s_nxt.leds = 4'((4'h1 << band) - 4'h1) | 4'({3'h0, s_r.slow_ph} << band);
			// [R10] Low battery blink
			else if (capacity_in < PCT_LOW)
				s_nxt.leds = {3'h0, s_r.fast_ph};
			// [R09] [R18] Discharge level bars
			else
				s_nxt.leds = 4'((4'h2 << band) - 4'h1);
		end
		else if (led_count_in == 3'h2)
		begin
			// [R19] Two LED patterns
			if (charging_in)
				s_nxt.leds = {3'h0, full_in | s_r.slow_ph};
			else if (capacity_in < PCT_LOW)
				s_nxt.leds = {2'h0, s_r.fast_ph, 1'h0};
			else
				s_nxt.leds = 4'h2;
		end
		else if (led_count_in == 3'h1)
		begin
			// [R19] Single LED patterns
			if (charging_in)
				s_nxt.leds = {3'h0, full_in | s_r.slow_ph};
			else if (capacity_in < PCT_LOW)
				s_nxt.leds = {3'h0, s_r.fast_ph};
			else
				s_nxt.leds = 4'h1;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign level_indicator_out = s_r.leds;
endmodule

// [core/supervisor_pkg.sv]
// Shared constants and carrier types for the charge box supervisor
package supervisor_pkg;
	// Clock and blink timing
	localparam int CLK_HZ = 50000000;
	localparam int FAST_BLINK_HZ = 1;
	localparam int SLOW_BLINK_DHZ = 5;
	localparam int HALF_FAST = CLK_HZ / (2 * FAST_BLINK_HZ);
	localparam int HALF_SLOW = (CLK_HZ * 10) / (2 * SLOW_BLINK_DHZ);
	localparam int STRAP_SETTLE = 1024;
	// Current codes in mA
	localparam logic [9:0] CUR_MAX_MA = 10'h1f4;
	localparam int PRE_DIVISOR = 10;
	localparam logic [9:0] DERATE_STEP_MA = 10'h064;
	// Capacity thresholds in percent
	localparam logic [6:0] PCT_75 = 7'h4b;
	localparam logic [6:0] PCT_50 = 7'h32;
	localparam logic [6:0] PCT_25 = 7'h19;
	localparam logic [6:0] PCT_66 = 7'h42;
	localparam logic [6:0] PCT_33 = 7'h21;
	localparam logic [6:0] PCT_LOW = 7'h03;

	typedef enum logic [2:0] {CH_IDLE, CH_PRE, CH_CC, CH_CV, CH_DONE} charge_state_t;

	// Analog comparator results
	typedef struct packed {
		logic bat_above_pre;
		logic bat_near_target;
		logic bat_below_rech;
		logic charge_end_current;
		logic ntc_above_1v30;
		logic ntc_below_0v50;
		logic ntc_above_1v47;
		logic ntc_below_0v44;
		logic die_hot;
		logic vin_sag;
		logic out_overcurrent;
		logic out_short;
		logic out_overvoltage;
		logic die_overtemp;
	} sense_t;

	// Charger and power stage commands
	typedef struct packed {
		logic charge_en;
		logic cv_mode;
		logic [9:0] current_ma;
		logic [1:0] target_sel;
		logic wireless_rx_disable;
		logic boost_en;
		logic ntc_bias_en;
	} power_cmd_t;
endpackage

// [tb/analog_side.sv]
// Behavioural charger, boost and comparator model
`timescale 1ns/1ns
module analog_side
	import supervisor_pkg::*;
(
	input wire power_cmd_t cmd_in,
	input wire logic bias_in,
	input wire logic [12:0] bat_mv_in,
	input wire logic [10:0] ntc_mv_in,
	input wire logic [5:0] stress_in,
	output sense_t sense_out
);
	logic [12:0] tgt;
	logic [10:0] ntc;
	always_comb
	begin
		case (cmd_in.target_sel)
			2'h0: tgt = 13'h1068;
			2'h1: tgt = 13'h10cc;
			2'h2: tgt = 13'h10fe;
			default: tgt = 13'h1130;
		endcase
		ntc = bias_in ? ntc_mv_in : 11'h000;
		sense_out = {bat_mv_in > 13'h0bb8, bat_mv_in >= tgt - 13'h032, bat_mv_in < 13'h1004,
			cmd_in.cv_mode && bat_mv_in >= tgt, ntc > 11'h514, ntc < 11'h1f4,
			ntc > 11'h5be, ntc < 11'h1b8, stress_in};
	end
endmodule

// [tb/supervisor_properties.sv]
// Port-level checks for the charge box supervisor
`timescale 1ns/1ns
module supervisor_properties
	import supervisor_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire sense_t sense_in,
	input wire logic wired_present_in,
	input wire logic wireless_present_in,
	input wire power_cmd_t power_cmd_out,
	input wire logic thermistor_sense_pin_bias_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	logic out_bad;
	assign out_bad = sense_in.out_overcurrent | sense_in.out_short | sense_in.out_overvoltage
		| sense_in.die_overtemp;
	////////////////////////////////////////////////////////////////////////////////
	property p_pre;
		!sense_in.bat_above_pre |=> !power_cmd_out.charge_en || power_cmd_out.current_ma <= 10'h032;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge current too high");
	property p_derate;
		sense_in.die_hot |=> power_cmd_out.current_ma <= 10'h190;
	endproperty
	a_derate: assert property (p_derate) else $error("current not derated");
	property p_wired;
		wired_present_in && wireless_present_in |=> power_cmd_out.wireless_rx_disable;
	endproperty
	a_wired: assert property (p_wired) else $error("wireless receiver left on");
	property p_bias;
		1'b1 |=> thermistor_sense_pin_bias_out;
	endproperty
	a_bias: assert property (p_bias) else $error("thermistor bias missing");
	property p_cold;
		power_cmd_out.charge_en && sense_in.ntc_above_1v30 |=> !power_cmd_out.charge_en;
	endproperty
	a_cold: assert property (p_cold) else $error("charging while cold");
	property p_hot;
		power_cmd_out.charge_en && sense_in.ntc_below_0v50 |=> !power_cmd_out.charge_en;
	endproperty
	a_hot: assert property (p_hot) else $error("charging while hot");
	property p_dcold;
		power_cmd_out.boost_en && sense_in.ntc_above_1v47 |=> !power_cmd_out.boost_en;
	endproperty
	a_dcold: assert property (p_dcold) else $error("boost while cold");
	property p_dhot;
		power_cmd_out.boost_en && sense_in.ntc_below_0v44 |=> !power_cmd_out.boost_en;
	endproperty
	a_dhot: assert property (p_dhot) else $error("boost while hot");
	property p_fault;
		out_bad |=> !power_cmd_out.boost_en [*2];
	endproperty
	a_fault: assert property (p_fault) else $error("boost kept on fault");
endmodule
bind charge_box_power_supervisor supervisor_properties chk (
	.ref_clk_in(ref_clk_in),
	.reset_in(reset_in),
	.sense_in(sense_in),
	.wired_present_in(wired_present_in),
	.wireless_present_in(wireless_present_in),
	.power_cmd_out(power_cmd_out),
	.thermistor_sense_pin_bias_out(thermistor_sense_pin_bias_out)
);

// [tb/tb.sv]
// Self-checking bench for the charge box supervisor
`timescale 1ns/1ns
module tb;
	import supervisor_pkg::*;
	logic clk, rst, wired, wireless, dreq, bias, chg, full, fault, batt;
	logic [1:0] tsel;
	logic [3:0] a_on, o_on;
	logic [12:0] bat_mv;
	logic [10:0] ntc_mv;
	logic [5:0] stress;
	logic [1:0] strap;
	logic [3:0] fit, leds;
	logic [6:0] cap;
	logic [2:0] mode;
	sense_t sense;
	power_cmd_t cmd;
	int err_total, comparisons, n;
	logic [6:0] caps[4] = '{7'h50, 7'h3c, 7'h1e, 7'h0a};
	logic [3:0] pats[4] = '{4'hf, 4'h7, 4'h3, 4'h1};
	logic [9:0] ccs[4] = '{10'h064, 10'h0c8, 10'h12c, 10'h1f4};
	logic [3:0] fits[4] = '{4'h1, 4'h2, 4'h8, 4'h4};
	logic [2:0] modes[4] = '{3'h1, 3'h2, 3'h4, 3'h3};
	charge_box_power_supervisor #(.HALF_FAST_CYC(4), .HALF_SLOW_CYC(8), .SETTLE_CYC(4)) uut (
		.ref_clk_in(clk), .reset_in(rst), .sense_in(sense), .wired_present_in(wired),
		.wireless_present_in(wireless), .battery_present_in(batt), .discharge_request_in(dreq),
		.target_select_in(tsel), .charge_current_select_pin_in(strap), .led_fitted_in(fit),
		.capacity_in(cap), .power_cmd_out(cmd), .thermistor_sense_pin_bias_out(bias),
		.charging_out(chg), .charge_full_out(full), .boost_fault_out(fault),
		.led_mode_out(mode), .level_indicator_out(leds));
	analog_side far (.cmd_in(cmd), .bias_in(bias), .bat_mv_in(bat_mv), .ntc_mv_in(ntc_mv),
		.stress_in(stress), .sense_out(sense));
	////////////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [9:0] ex, input logic [9:0] got);
		comparisons++;
		if (got !== ex)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task wait_n(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	// Counts one LED high and collects steady and ever-lit LEDs
	task automatic watch(input int k, input int b, output int ones, output logic [3:0] all_on,
		output logic [3:0] any_on);
		ones = 0;
		all_on = 4'hf;
		any_on = 4'h0;
		repeat (k)
		begin
			ones += leds[b];
			all_on &= leds;
			any_on |= leds;
			@(negedge clk);
		end
	endtask
	// Straps settle after release, so wait past that
	task do_reset;
		@(posedge clk);
		rst <= 1'b1;
		wait_n(5);
		chk("mode_rst", 10'h001, mode);
		chk("cmd_rst", 10'h000, cmd.current_ma);
		@(posedge clk);
		rst <= 1'b0;
		wait_n(10);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		close_out;
	end
	initial
	begin
		{wired, wireless, dreq, stress, cap, tsel} = '0;
		rst = 1'b1;
		batt = 1'b1;
		strap = 2'h3;
		fit = 4'h8;
		bat_mv = 13'h0a8c;
		ntc_mv = 11'h384;
		do_reset;
		chk("mode", 10'h004, mode);
		@(posedge clk);
		wired <= 1'b1;
		wait_n(2);
		chk("pre", 10'h032, cmd.current_ma);
		chk("charging", 10'h001, chg);
		@(posedge clk);
		bat_mv <= 13'h0e74;
		wait_n(2);
		chk("cc", 10'h1f4, cmd.current_ma);
		@(posedge clk);
		stress <= 6'h20;
		wait_n(2);
		chk("derate", 10'h190, cmd.current_ma);
		@(posedge clk);
		stress <= 6'h00;
		bat_mv <= 13'h1040;
		wait_n(2);
		chk("cv", 10'h001, cmd.cv_mode);
		@(posedge clk);
		bat_mv <= 13'h1068;
		wait_n(3);
		chk("full", 10'h001, full);
		@(posedge clk);
		bat_mv <= 13'h0fa0;
		wait_n(3);
		chk("rech", 10'h001, cmd.charge_en);
		@(posedge clk);
		ntc_mv <= 11'h546;
		wait_n(2);
		chk("cold", 10'h000, cmd.charge_en);
		@(posedge clk);
		ntc_mv <= 11'h190;
		wait_n(2);
		chk("hot", 10'h000, cmd.charge_en);
		@(posedge clk);
		ntc_mv <= 11'h384;
		wireless <= 1'b1;
		wait_n(2);
		chk("rx_off", 10'h001, cmd.wireless_rx_disable);
		@(posedge clk);
		cap <= 7'h3c;
		wait_n(3);
		watch(32, 2, n, a_on, o_on);
		chk("chg_blink", 10'h010, n[9:0]);
		chk("chg_lower", 10'h003, {6'h00, a_on});
		chk("chg_upper", 10'h007, {6'h00, o_on});
		@(posedge clk);
		{wired, wireless, dreq} <= 3'b001;
		for (int i = 0; i < 4; i++)
		begin
			cap <= caps[i];
			wait_n(3);
			chk("bars", {6'h00, pats[i]}, {6'h00, leds});
			@(posedge clk);
		end
		cap <= 7'h02;
		wait_n(3);
		watch(16, 0, n, a_on, o_on);
		chk("blink", 10'h008, n[9:0]);
		chk("others", 10'h000, {7'h00, o_on[3:1]});
		chk("boost", 10'h001, cmd.boost_en);
		@(posedge clk);
		ntc_mv <= 11'h5dc;
		wait_n(2);
		chk("dcold", 10'h000, cmd.boost_en);
		@(posedge clk);
		ntc_mv <= 11'h384;
		wait_n(2);
		chk("dwarm", 10'h001, cmd.boost_en);
		@(posedge clk);
		ntc_mv <= 11'h190;
		wait_n(2);
		chk("dhot", 10'h000, cmd.boost_en);
		@(posedge clk);
		ntc_mv <= 11'h384;
		stress <= 6'h04;
		wait_n(2);
		chk("fault", 10'h001, fault);
		@(posedge clk);
		{stress, dreq, wired} <= 8'h01;
		bat_mv <= 13'h0e74;
		for (int i = 0; i < 4; i++)
		begin
			strap <= i[1:0];
			tsel <= i[1:0];
			fit <= fits[i];
			do_reset;
			chk("strap", ccs[i], cmd.current_ma);
			chk("led_mode", {7'h00, modes[i]}, {7'h00, mode});
			chk("tsel", 10'(i), {8'h00, cmd.target_sel});
			watch(16, 0, n, a_on, o_on);
			chk("level_indicator_1_blink", 10'h008, n[9:0]);
			chk("led_rest", 10'h001, {6'h00, o_on});
		end
		@(posedge clk);
		batt <= 1'b0;
		wait_n(2);
		chk("no_batt", 10'h000, chg);
		chk("no_batt_cur", 10'h000, cmd.current_ma);
		@(posedge clk);
		{batt, wired} <= 2'b10;
		cap <= 7'h3c;
		wait_n(3);
		chk("bars3", 10'h003, {6'h00, leds});
		close_out;
	end
endmodule
